// ---- secp_pkg.sv ----
/*
  Constants for the sector protection block: command codes, register
  layouts, reset values, array geometry and timing.
  Assumes a 250 MHz core clock and a 1 Gbit array with 64KB blocks.
*/
package secp_pkg;
  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_LOCK_REG_PROGRAM = 8'h2C;
  localparam logic [7:0] CMD_LOCK_REG_READ = 8'h2D;
  localparam logic [7:0] CMD_SOLID_LOCK = 8'hA6;
  localparam logic [7:0] CMD_UNLOCK_FLAG_READ = 8'hA7;
  localparam logic [7:0] CMD_PASSWORD_UNLOCK = 8'h29;
  localparam logic [7:0] CMD_SOLID_BIT_SET = 8'hE3;
  localparam logic [7:0] CMD_SOLID_BITS_CLEAR_ALL = 8'hE4;
  localparam logic [7:0] CMD_SOLID_BIT_READ = 8'hE2;
  localparam logic [7:0] CMD_DYNAMIC_BIT_WRITE = 8'hE1;
  localparam logic [7:0] CMD_DYNAMIC_BIT_READ = 8'hE0;
  localparam logic [7:0] CMD_GLOBAL_PROTECT = 8'h7E;
  localparam logic [7:0] CMD_GLOBAL_UNPROTECT = 8'h98;
  // ****************************************************************
  // Register layouts and reset values
  // ****************************************************************
  localparam int LOCK_W = 16;
  localparam int LOCK_PASSWORD_BIT = 2;
  localparam int LOCK_SOLID_BIT = 1;
  localparam logic [15:0] LOCK_RESERVED_READ = 16'hFFF9;
  localparam logic [1:0] LOCK_MODE_RESET = 2'h3;
  localparam logic [7:0] BYTE_CLEAR = 8'h00;
  localparam logic [7:0] BYTE_SET = 8'hFF;
  localparam logic SOLID_RESET = 1'b0;
  localparam logic DYNAMIC_RESET = 1'b1;
  localparam logic UNLOCK_RESET = 1'b1;
  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_W = 27;
  localparam int IDX_W = 12;
  localparam int BLOCK_LSB = 16;
  localparam int SECTOR_LSB = 12;
  localparam int EDGE_SECTORS = 16;
  localparam int NUM_BLOCKS = 2048;
  localparam int NUM_UNITS = 2 * EDGE_SECTORS + NUM_BLOCKS - 2;
  localparam int TOP_BASE = EDGE_SECTORS + NUM_BLOCKS - 2;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FAIL_WAIT_US = 100;
  localparam int FAIL_WAIT_CYCLES =
    (FAIL_WAIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int BUSY_W = 16;
endpackage

// ---- secp_protect.sv ----
/*
  Sector protection logic: mode lock register, unlock flag, solid and
  dynamic protect bits (one per edge sector or block), and the combined protect check.
  Assumes commands come from host logic on the link clock linkClk, and
  that the latch, scheme select and password match come from core logic.
*/
`timescale 1ns/1ps
module secp_protect #(
  parameter int FAIL_WAIT = secp_pkg::FAIL_WAIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic hostCmdValid,
  output logic hostCmdReady,
  input wire logic [7:0] hostCmdCode,
  input wire logic [secp_pkg::ADDR_W-1:0] hostCmdAddr,
  input wire logic [15:0] hostCmdData,
  output logic hostRespValid,
  output logic [15:0] hostRespData,
  input wire logic softReset,
  input wire logic writeEnableLatch,
  input wire logic protectionSchemeSelect,
  input wire logic passwordMatch,
  input wire logic writeProtect_n,
  input wire logic [secp_pkg::ADDR_W-1:0] chkAddr,
  output logic chkProtected,
  output logic progFailSet,
  output logic writeLatchClear,
  output logic protBusy,
  output logic solidBitsUnlockFlag
);
  import secp_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [IDX_W-1:0] unitIndex(
    input logic [ADDR_W-1:0] a);
    logic [ADDR_W-BLOCK_LSB-1:0] blk;
    blk = a[ADDR_W-1:BLOCK_LSB];
    if (blk == '0) begin
      unitIndex = IDX_W'(a[BLOCK_LSB-1:SECTOR_LSB]);
    end else if (&blk) begin
      unitIndex = IDX_W'(TOP_BASE) + IDX_W'(a[BLOCK_LSB-1:SECTOR_LSB]);
    end else begin
      unitIndex = IDX_W'(EDGE_SECTORS - 1) + IDX_W'(blk);
    end
  endfunction

  function automatic logic [4:0] countOnes(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < LOCK_W; i++) begin
      n = n + 5'(v[i]);
    end
    countOnes = n;
  endfunction

  function automatic logic isModify(input logic [7:0] c);
    isModify = (c == CMD_LOCK_REG_PROGRAM) || (c == CMD_SOLID_LOCK) ||
      (c == CMD_PASSWORD_UNLOCK) || (c == CMD_SOLID_BIT_SET) ||
      (c == CMD_SOLID_BITS_CLEAR_ALL) || (c == CMD_DYNAMIC_BIT_WRITE) ||
      (c == CMD_GLOBAL_PROTECT) || (c == CMD_GLOBAL_UNPROTECT);
  endfunction

  // ****************************************************************
  // Link side command capture
  // ****************************************************************
  logic pendingReg;
  logic reqTglReg;
  logic [7:0] cmdCodeReg;
  logic [ADDR_W-1:0] cmdAddrReg;
  logic [15:0] cmdDataReg;
  logic ackSync1Reg;
  logic ackSync2Reg;
  logic ackTglReg;
  logic [15:0] respReg;

  assign hostCmdReady = !pendingReg;

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      ackSync1Reg <= 1'b0;
      ackSync2Reg <= 1'b0;
    end else begin
      ackSync1Reg <= ackTglReg;
      ackSync2Reg <= ackSync1Reg;
    end
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      pendingReg <= 1'b0;
      reqTglReg <= 1'b0;
      cmdCodeReg <= 8'h00;
      cmdAddrReg <= '0;
      cmdDataReg <= 16'h0000;
    end else if (!pendingReg && hostCmdValid) begin
      pendingReg <= 1'b1;
      reqTglReg <= !reqTglReg;
      cmdCodeReg <= hostCmdCode;
      cmdAddrReg <= hostCmdAddr;
      cmdDataReg <= hostCmdData;
    end else if (pendingReg && (ackSync2Reg == reqTglReg)) begin
      pendingReg <= 1'b0;
    end
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      hostRespValid <= 1'b0;
      hostRespData <= 16'h0000;
    end else begin
      hostRespValid <= pendingReg && (ackSync2Reg == reqTglReg);
      if (pendingReg && (ackSync2Reg == reqTglReg)) begin
        hostRespData <= respReg;
      end
    end
  end

  // ****************************************************************
  // Core side synchronisers
  // ****************************************************************
  logic reqSync1Reg;
  logic reqSync2Reg;
  logic reqSeenReg;
  logic wpSync1Reg;
  logic wpSync2Reg;
  logic execNow;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reqSync1Reg <= 1'b0;
      reqSync2Reg <= 1'b0;
      reqSeenReg <= 1'b0;
      wpSync1Reg <= 1'b1;
      wpSync2Reg <= 1'b1;
    end else begin
      reqSync1Reg <= reqTglReg;
      reqSync2Reg <= reqSync1Reg;
      reqSeenReg <= reqSync2Reg;
      wpSync1Reg <= writeProtect_n;
      wpSync2Reg <= wpSync1Reg;
    end
  end

  assign execNow = reqSync2Reg ^ reqSeenReg;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [BUSY_W-1:0] busyCountReg;
  logic accepted;
  logic modOk;
  logic [IDX_W-1:0] cmdIdx;
  logic [15:0] lockRead;
  logic [15:0] lockClearMask;
  logic lockMulti;
  logic [1:0] modeLockReg;
  logic unlockFlagReg;
  logic [NUM_UNITS-1:0] solidBitsReg;
  logic [NUM_UNITS-1:0] dynamicBitsReg;
  logic badUnlock;

  assign protBusy = busyCountReg != '0;
  assign accepted = execNow && protectionSchemeSelect && !protBusy;
  assign modOk = accepted && writeEnableLatch && isModify(cmdCodeReg);
  assign cmdIdx = unitIndex(cmdAddrReg);
  assign lockRead = LOCK_RESERVED_READ |
    (16'(modeLockReg[1]) << LOCK_PASSWORD_BIT) |
    (16'(modeLockReg[0]) << LOCK_SOLID_BIT);
  assign lockClearMask = lockRead & ~cmdDataReg;
  assign lockMulti = countOnes(lockClearMask) > 5'h01;
  assign badUnlock = modOk && (cmdCodeReg == CMD_PASSWORD_UNLOCK) &&
    !(modeLockReg[1] == 1'b0 && passwordMatch);
  assign solidBitsUnlockFlag = unlockFlagReg;

  // ****************************************************************
  // Mode lock register (one-time programmable)
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modeLockReg <= LOCK_MODE_RESET;
    end else if (modOk && cmdCodeReg == CMD_LOCK_REG_PROGRAM &&
                 !lockMulti && (&modeLockReg)) begin
      modeLockReg <= modeLockReg & {cmdDataReg[LOCK_PASSWORD_BIT],
                                    cmdDataReg[LOCK_SOLID_BIT]};
    end
  end

  // ****************************************************************
  // Unlock flag
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unlockFlagReg <= UNLOCK_RESET;
    end else if (softReset) begin
      unlockFlagReg <= modeLockReg[1];
    end else if (modOk && cmdCodeReg == CMD_SOLID_LOCK) begin
      unlockFlagReg <= 1'b0;
    end else if (modOk && cmdCodeReg == CMD_PASSWORD_UNLOCK &&
                 !badUnlock) begin
      unlockFlagReg <= 1'b1;
    end
  end

  // ****************************************************************
  // Solid protect bits
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      solidBitsReg <= {NUM_UNITS{SOLID_RESET}};
    end else if (modOk && unlockFlagReg) begin
      if (cmdCodeReg == CMD_SOLID_BIT_SET) begin
        solidBitsReg[cmdIdx] <= 1'b1;
      end else if (cmdCodeReg == CMD_SOLID_BITS_CLEAR_ALL) begin
        solidBitsReg <= {NUM_UNITS{1'b0}};
      end
    end
  end

  // ****************************************************************
  // Dynamic protect bits
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dynamicBitsReg <= {NUM_UNITS{DYNAMIC_RESET}};
    end else if (softReset) begin
      dynamicBitsReg <= {NUM_UNITS{DYNAMIC_RESET}};
    end else if (modOk) begin
      if (cmdCodeReg == CMD_DYNAMIC_BIT_WRITE) begin
        dynamicBitsReg[cmdIdx] <= cmdDataReg[0];
      end else if (cmdCodeReg == CMD_GLOBAL_PROTECT) begin
        dynamicBitsReg <= {NUM_UNITS{1'b1}};
      end else if (cmdCodeReg == CMD_GLOBAL_UNPROTECT) begin
        dynamicBitsReg <= {NUM_UNITS{1'b0}};
      end
    end
  end

  // ****************************************************************
  // Fail flag, busy timer, latch clear, read answers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      progFailSet <= 1'b0;
      writeLatchClear <= 1'b0;
    end else begin
      progFailSet <= badUnlock || (modOk && lockMulti &&
        cmdCodeReg == CMD_LOCK_REG_PROGRAM);
      writeLatchClear <= modOk;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busyCountReg <= '0;
    end else if (badUnlock) begin
      busyCountReg <= BUSY_W'(FAIL_WAIT);
    end else if (protBusy) begin
      busyCountReg <= busyCountReg - BUSY_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      respReg <= 16'h0000;
      ackTglReg <= 1'b0;
    end else if (execNow) begin
      ackTglReg <= reqSync2Reg;
      respReg <= 16'h0000;
      if (accepted) begin
        unique case (cmdCodeReg)
          CMD_LOCK_REG_READ: respReg <= lockRead;
          CMD_UNLOCK_FLAG_READ: respReg <= {15'h0000, unlockFlagReg};
          CMD_SOLID_BIT_READ: respReg <= {BYTE_CLEAR,
            solidBitsReg[cmdIdx] ? BYTE_SET : BYTE_CLEAR};
          CMD_DYNAMIC_BIT_READ: respReg <= {BYTE_CLEAR,
            dynamicBitsReg[cmdIdx] ? BYTE_SET : BYTE_CLEAR};
          default: respReg <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Protect check
  // ****************************************************************
  logic [IDX_W-1:0] chkIdx;
  assign chkIdx = unitIndex(chkAddr);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chkProtected <= 1'b1;
    end else begin
      chkProtected <= protectionSchemeSelect && (!wpSync2Reg ||
        solidBitsReg[chkIdx] || dynamicBitsReg[chkIdx]);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence failStart;
    badUnlock;
  endsequence
  sequence busyHeld;
    protBusy [*8];
  endsequence

  AST_LOCK_OTP: assert property (@(posedge mclk) disable iff (!rst_n)
    !$rose(modeLockReg[1]) && !$rose(modeLockReg[0]))
    else $error("mode lock bit returned to one");
  AST_MODE_EXCL: assert property (@(posedge mclk) disable iff (!rst_n)
    modeLockReg != 2'h0)
    else $error("both mode lock bits cleared");
  AST_LOCK_FAIL: assert property (@(posedge mclk) disable iff (!rst_n)
    (modOk && cmdCodeReg == CMD_LOCK_REG_PROGRAM && lockMulti)
    |=> progFailSet && $stable(modeLockReg))
    else $error("multi-bit lock clear not failed");
  AST_FLAG_STUCK: assert property (@(posedge mclk) disable iff (!rst_n)
    (!unlockFlagReg && !softReset && modeLockReg[1]) |=> !unlockFlagReg)
    else $error("unlock flag set again in solid mode");
  AST_SOFT_RST: assert property (@(posedge mclk) disable iff (!rst_n)
    softReset |=> unlockFlagReg == modeLockReg[1] && (&dynamicBitsReg))
    else $error("reset defaults wrong");
  AST_SOLID_LOCKED: assert property (@(posedge mclk) disable iff (!rst_n)
    (execNow && !unlockFlagReg) |=> $stable(solidBitsReg))
    else $error("solid bits changed while locked");
  AST_NO_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    (execNow && !writeEnableLatch && !softReset) |=>
    $stable(solidBitsReg) && $stable(dynamicBitsReg) &&
    $stable(unlockFlagReg) && !progFailSet)
    else $error("change without write latch");
  AST_WP_PIN: assert property (@(posedge mclk) disable iff (!rst_n)
    (!wpSync2Reg && protectionSchemeSelect) |=> chkProtected)
    else $error("write protect pin ignored");
  AST_BUSY_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    failStart |=> busyHeld ##1 progFailSet == 1'b0)
    else $error("busy not held after bad password");
  AST_SOLID_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    (accepted && cmdCodeReg == CMD_SOLID_BIT_READ) |=>
    respReg[7:0] == {8{$past(solidBitsReg[cmdIdx])}})
    else $error("solid read value wrong");
  AST_DYN_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    (accepted && cmdCodeReg == CMD_DYNAMIC_BIT_READ) |=>
    respReg[7:0] == {8{$past(dynamicBitsReg[cmdIdx])}})
    else $error("dynamic read value wrong");
endmodule // secp_protect

// ---- secp_host_model.sv ----
/*
  Host command model: offers one command at a time on the link clock
  and collects the answer word.
  Assumes the block under test answers within a few link cycles.
*/
`timescale 1ns/1ps
module secp_host_model (
  input wire logic linkClk,
  output logic hostCmdValid,
  input wire logic hostCmdReady,
  output logic [7:0] hostCmdCode,
  output logic [secp_pkg::ADDR_W-1:0] hostCmdAddr,
  output logic [15:0] hostCmdData,
  input wire logic hostRespValid,
  input wire logic [15:0] hostRespData
);
  import secp_pkg::*;
  // ****************************************************************
  // Idle lines
  // ****************************************************************
  initial begin
    hostCmdValid = 1'b0;
    hostCmdCode = 8'h00;
    hostCmdAddr = '0;
    hostCmdData = 16'h0000;
  end
  // ****************************************************************
  // One command, held until taken, then lines scrambled
  // ****************************************************************
  task automatic issue(input logic [7:0] code,
    input logic [ADDR_W-1:0] addr, input logic [15:0] data,
    input int gap, output logic [15:0] resp, output bit ok);
    int n;
    repeat (gap) @(negedge linkClk);
    @(negedge linkClk);
    hostCmdValid = 1'b1;
    hostCmdCode = code;
    hostCmdAddr = addr;
    hostCmdData = data;
    n = 0;
    while (hostCmdReady !== 1'b1 && n < 20) begin
      @(negedge linkClk);
      n++;
    end
    @(posedge linkClk);
    @(negedge linkClk);
    hostCmdValid = 1'b0;
    hostCmdCode = ~code;
    hostCmdAddr = ~addr;
    hostCmdData = ~data;
    ok = 0;
    resp = 16'h0000;
    n = 0;
    while (!ok && n < 16) begin
      if (hostRespValid === 1'b1) begin
        resp = hostRespData;
        ok = 1;
      end else begin
        @(negedge linkClk);
        n++;
      end
    end
  endtask
endmodule // secp_host_model

// ---- secp_protect_tb.sv ----
/*
  Self-checking bench for the sector protection block.
  Assumes the host model above and a shortened wrong-password wait.
*/
`timescale 1ns/1ps
module secp_protect_tb;
  import secp_pkg::*;
  localparam int FW = 20;
  logic mclk = 1'b0, linkClk = 1'b0, rst_n = 1'b0;
  logic hostCmdValid, hostCmdReady, hostRespValid;
  logic [7:0] hostCmdCode;
  logic [ADDR_W-1:0] hostCmdAddr, chkAddr = '0;
  logic [15:0] hostCmdData, hostRespData;
  logic softReset = 1'b0, writeEnableLatch = 1'b1, passwordMatch = 1'b0;
  logic protectionSchemeSelect = 1'b1, writeProtect_n = 1'b1;
  logic chkProtected, progFailSet, writeLatchClear, protBusy, flag;
  int nMismatch = 0, totalChecks = 0, nFail = 0, nWlc = 0, nBusy = 0;
  // ****************************************************************
  // Clocks, instances, pulse counters
  // ****************************************************************
  always #2 mclk = ~mclk;
  initial begin
    #0.5 linkClk = 1'b1;
    forever #7.5 linkClk = ~linkClk;
  end
  secp_protect #(.FAIL_WAIT(FW)) dut (.mclk(mclk), .rst_n(rst_n),
    .linkClk(linkClk), .hostCmdValid(hostCmdValid),
    .hostCmdReady(hostCmdReady), .hostCmdCode(hostCmdCode),
    .hostCmdAddr(hostCmdAddr), .hostCmdData(hostCmdData),
    .hostRespValid(hostRespValid), .hostRespData(hostRespData),
    .softReset(softReset), .writeEnableLatch(writeEnableLatch),
    .protectionSchemeSelect(protectionSchemeSelect),
    .passwordMatch(passwordMatch), .writeProtect_n(writeProtect_n),
    .chkAddr(chkAddr), .chkProtected(chkProtected),
    .progFailSet(progFailSet), .writeLatchClear(writeLatchClear),
    .protBusy(protBusy), .solidBitsUnlockFlag(flag));
  secp_host_model host (.linkClk(linkClk), .hostCmdValid(hostCmdValid),
    .hostCmdReady(hostCmdReady), .hostCmdCode(hostCmdCode),
    .hostCmdAddr(hostCmdAddr), .hostCmdData(hostCmdData),
    .hostRespValid(hostRespValid), .hostRespData(hostRespData));
  always @(negedge mclk) begin
    if (progFailSet === 1'b1) nFail++;
    if (writeLatchClear === 1'b1) nWlc++;
    if (protBusy === 1'b1) nBusy++;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c, input logic [ADDR_W-1:0] a,
    input logic [15:0] d, output logic [15:0] r);
    bit ok;
    host.issue(c, a, d, 1, r, ok);
    cmp(16'(ok), 16'h0001);
  endtask
  task automatic rd(input logic [7:0] c, input logic [ADDR_W-1:0] a,
    input logic [15:0] exp);
    logic [15:0] r;
    op(c, a, 16'h0000, r);
    cmp(r, exp);
  endtask
  task automatic wr(input logic [7:0] c, input logic [ADDR_W-1:0] a,
    input logic [15:0] d);
    logic [15:0] r;
    op(c, a, d, r);
  endtask
  task automatic probe(input logic [ADDR_W-1:0] a, input logic exp);
    @(negedge mclk) chkAddr = a;
    repeat (2) @(negedge mclk);
    cmp(16'(chkProtected), 16'(exp));
  endtask
  task automatic core(input logic write_enable_latch, input logic sel);
    @(negedge mclk);
    writeEnableLatch = write_enable_latch;
    protectionSchemeSelect = sel;
  endtask
  task automatic soft_pulse();
    @(negedge mclk) softReset = 1'b1;
    @(negedge mclk) softReset = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic do_reset();
    @(negedge mclk) rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(CMD_UNLOCK_FLAG_READ, '0, 16'h0001);
    cmp(16'(flag), 16'h0001);
    rd(CMD_DYNAMIC_BIT_READ, 27'h0020000, 16'h00FF);
    rd(CMD_SOLID_BIT_READ, 27'h0020000, 16'h0000);
    rd(CMD_LOCK_REG_READ, '0, 16'hFFFF);
    probe(27'h0020000, 1'b1);
  endtask
  task automatic t_dynamic();
    int w;
    w = nWlc;
    wr(CMD_GLOBAL_UNPROTECT, '0, 16'h0000);
    probe(27'h0020000, 1'b0);
    cmp(16'(nWlc - w), 16'h0001);
    wr(CMD_DYNAMIC_BIT_WRITE, 27'h0000000, 16'h0001);
    wr(CMD_DYNAMIC_BIT_WRITE, 27'h0020000, 16'h0001);
    probe(27'h0000000, 1'b1);
    probe(27'h0001000, 1'b0);
    probe(27'h002F000, 1'b1);
    probe(27'h0030000, 1'b0);
    rd(CMD_DYNAMIC_BIT_READ, 27'h0001000, 16'h0000);
    wr(CMD_DYNAMIC_BIT_WRITE, 27'h0020000, 16'h0000);
    probe(27'h0020000, 1'b0);
  endtask
  task automatic t_solid();
    wr(CMD_SOLID_BIT_SET, 27'h0030000, 16'h0000);
    rd(CMD_SOLID_BIT_READ, 27'h0030000, 16'h00FF);
    rd(CMD_SOLID_BIT_READ, 27'h0040000, 16'h0000);
    probe(27'h0030000, 1'b1);
    wr(CMD_SOLID_BITS_CLEAR_ALL, '0, 16'h0000);
    rd(CMD_SOLID_BIT_READ, 27'h0030000, 16'h0000);
    probe(27'h0030000, 1'b0);
  endtask
  task automatic t_guards();
    int w;
    w = nWlc;
    core(1'b0, 1'b1);
    wr(CMD_GLOBAL_PROTECT, '0, 16'h0000);
    probe(27'h0030000, 1'b0);
    cmp(16'(nWlc - w), 16'h0000);
    core(1'b1, 1'b0);
    rd(CMD_DYNAMIC_BIT_READ, 27'h0000000, 16'h0000);
    core(1'b1, 1'b1);
    wr(CMD_GLOBAL_PROTECT, '0, 16'h0000);
    probe(27'h0030000, 1'b1);
    wr(CMD_GLOBAL_UNPROTECT, '0, 16'h0000);
    @(negedge mclk) writeProtect_n = 1'b0;
    repeat (4) @(negedge mclk);
    probe(27'h0030000, 1'b1);
    @(negedge mclk) writeProtect_n = 1'b1;
    repeat (4) @(negedge mclk);
    probe(27'h0030000, 1'b0);
  endtask
  task automatic t_lock_solid();
    wr(CMD_SOLID_LOCK, '0, 16'h0000);
    rd(CMD_UNLOCK_FLAG_READ, '0, 16'h0000);
    cmp(16'(flag), 16'h0000);
    wr(CMD_SOLID_BIT_SET, 27'h0030000, 16'h0000);
    rd(CMD_SOLID_BIT_READ, 27'h0030000, 16'h0000);
    @(negedge mclk) passwordMatch = 1'b1;
    wr(CMD_PASSWORD_UNLOCK, '0, 16'h0000);
    repeat (FW + 10) @(negedge mclk);
    rd(CMD_UNLOCK_FLAG_READ, '0, 16'h0000);
    soft_pulse();
    rd(CMD_UNLOCK_FLAG_READ, '0, 16'h0001);
    rd(CMD_DYNAMIC_BIT_READ, 27'h0030000, 16'h00FF);
  endtask
  task automatic t_password();
    int f, b;
    wr(CMD_LOCK_REG_PROGRAM, '0, 16'hFFFB);
    rd(CMD_LOCK_REG_READ, '0, 16'hFFFB);
    soft_pulse();
    rd(CMD_UNLOCK_FLAG_READ, '0, 16'h0000);
    @(negedge mclk) passwordMatch = 1'b0;
    f = nFail;
    b = nBusy;
    wr(CMD_PASSWORD_UNLOCK, '0, 16'h0000);
    repeat (FW + 10) @(negedge mclk);
    cmp(16'(nFail - f), 16'h0001);
    cmp(16'(nBusy - b >= FW && nBusy - b <= FW + 2), 16'h0001);
    rd(CMD_UNLOCK_FLAG_READ, '0, 16'h0000);
    @(negedge mclk) passwordMatch = 1'b1;
    wr(CMD_PASSWORD_UNLOCK, '0, 16'h0000);
    rd(CMD_UNLOCK_FLAG_READ, '0, 16'h0001);
    wr(CMD_SOLID_BIT_SET, 27'h0030000, 16'h0000);
    rd(CMD_SOLID_BIT_READ, 27'h0030000, 16'h00FF);
  endtask
  task automatic t_lock_reg();
    int f;
    do_reset();
    cmp(16'(flag), 16'h0001);
    f = nFail;
    wr(CMD_LOCK_REG_PROGRAM, '0, 16'hFFF9);
    cmp(16'(nFail - f), 16'h0001);
    rd(CMD_LOCK_REG_READ, '0, 16'hFFFF);
    wr(CMD_LOCK_REG_PROGRAM, '0, 16'hFFFD);
    rd(CMD_LOCK_REG_READ, '0, 16'hFFFD);
    wr(CMD_LOCK_REG_PROGRAM, '0, 16'hFFFB);
    rd(CMD_LOCK_REG_READ, '0, 16'hFFFD);
    rd(CMD_SOLID_BIT_READ, 27'h0030000, 16'h0000);
  endtask
  // ****************************************************************
  // Verdict, watchdog, main sequence
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    nMismatch++;
    $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_dynamic();
    t_solid();
    t_guards();
    t_lock_solid();
    t_password();
    t_lock_reg();
    print_verdict();
  end
endmodule // secp_protect_tb
